// >>> jdr_top.sv
// debug scan data registers behind a test access port, with an APB slave for the debug handler.
// assumes tck/tms/tdi/trst_b and the reset pin are asynchronous to clk and tck is well below clk/4.
// Functional notes
// R1: one 36-bit scan register shared by three instructions
// R2: code 01001 selects control/status access
// R3: code 10000 selects transmit poll
// R4: code 00010 selects receive write
// R5: control/status capture fills scan bits 34:3
// R6: update loads holding 33:2, writes writable bits
// R7: capture forces scan bit 1 high
// R8: hold-in-reset keeps core reset past pin release
// R9: hold-in-reset cleared by scanning zero or by test reset
// R10: scan bit 2 set requests external break
// R11: break pends until exception, deferred abort/special state
// R12: transmit capture loads buffer and ready flag
// R13: transmit poll update has no effect
// R14: shift-out read clears transmit ready
// R15: receive capture loads receive-ready into bit 0
// R16: receive update copies scan 35:1 to holding
// R17: receive buffer written only for new valid data
// R18: write logic clears valid holding bit after use
// R19: debugger receive write sets receive ready
// R20: write while receive ready set flags overflow; the code does not flag it when the flush bit is also set
// R21: download flag goes straight to bit 29
// R22: flush bit clears receive ready
// R23: test reset clears holding 0,1,34 only
// R24: handler transmit write sets transmit ready
// R25: scan register shifts lsb first
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`include "jdr_defines.svh"

module jdr_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_b,
  input wire logic sys_reset_pin,
  input wire jdr_pkg::jdr_core_status_t core_status,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`JDR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic tdo,
  output logic tdo_en,
  output logic core_hold_reset,
  output logic core_break_request
);
  import jdr_pkg::*;

  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic tck_prev_reg;
  jdr_tap_state_t tap_reg;
  jdr_tap_state_t tap_next;
  logic [`JDR_IR_W-1:0] ir_shift_reg;
  logic [`JDR_IR_W-1:0] ir_reg;
  logic [`JDR_SCAN_W-1:0] debug_scan_shift;
  logic [`JDR_HOLD_W-1:0] debug_scan_holding;
  logic bypass_reg;
  logic rx_write_pulse_reg;
  logic cs_update_pulse_reg;
  logic tx_cap_reg;
  logic [31:0] debug_control_status;
  logic [31:0] tx_buf_reg;
  logic [31:0] rx_buf_reg;
  logic receive_ready_reg;
  logic overflow_reg;
  logic download_reg;
  logic transmit_ready_flag;
  logic hold_in_reset_bit;
  logic hold_active_reg;
  logic external_break_request;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic tdo_reg;
  logic tdo_en_reg;
  logic core_hold_reg;
  logic core_break_reg;
  logic [31:0] rdata_next;
  logic hit_next;

  // pin synchronisers: tck, tms, tdi, trst_b, reset pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      tck_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {tck, tms, tdi, trst_b, sys_reset_pin};
      sync2_reg <= sync1_reg;
      tck_prev_reg <= sync2_reg[4];
    end
  end

  wire tck_rise = sync2_reg[4] & ~tck_prev_reg;
  wire tck_fall = ~sync2_reg[4] & tck_prev_reg;
  wire tms_s = sync2_reg[3];
  wire tdi_s = sync2_reg[2];
  wire jtag_rst = ~sync2_reg[1];
  wire pin_rst = sync2_reg[0];

  wire sel_cs = (ir_reg == `JDR_IR_CTRL_STATUS); // [R2]
  wire sel_tx = (ir_reg == `JDR_IR_TRANSMIT_POLL); // [R3]
  wire sel_rx = (ir_reg == `JDR_IR_RECEIVE_WRITE); // [R4]
  wire sel_dbg = sel_cs | sel_tx | sel_rx;
  wire tap_act = tck_rise & ~jtag_rst;

  always_comb begin
    tap_next = tap_reg;
    unique case (tap_reg)
      TAP_TLR: tap_next = tms_s ? TAP_TLR : TAP_RTI;
      TAP_RTI: tap_next = tms_s ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: tap_next = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tap_next = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms_s ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tap_next = tms_s ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tap_next = tms_s ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = tms_s ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: tap_next = tms_s ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tap_next = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms_s ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tap_next = tms_s ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tap_next = tms_s ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = tms_s ? TAP_SEL_DR : TAP_RTI;
      default: tap_next = TAP_TLR;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tap_reg <= TAP_TLR;
    end else if (jtag_rst) begin
      tap_reg <= TAP_TLR;
    end else if (tck_rise) begin
      tap_reg <= tap_next;
    end
  end

  // instruction register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_shift_reg <= `JDR_IR_RESET_VALUE;
      ir_reg <= `JDR_IR_RESET_VALUE;
    end else if (jtag_rst || (tck_rise && tap_reg == TAP_TLR)) begin
      ir_shift_reg <= `JDR_IR_RESET_VALUE;
      ir_reg <= `JDR_IR_RESET_VALUE;
    end else if (tck_rise) begin
      if (tap_reg == TAP_CAP_IR) begin
        ir_shift_reg <= `JDR_IR_CAPTURE_VALUE;
      end else if (tap_reg == TAP_SH_IR) begin
        ir_shift_reg <= {tdi_s, ir_shift_reg[`JDR_IR_W-1:1]};
      end else if (tap_reg == TAP_UPD_IR) begin
        ir_reg <= ir_shift_reg;
      end
    end
  end

  // shared scan shift register and bypass
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      debug_scan_shift <= 36'h0;
      bypass_reg <= 1'b0;
    end else if (tap_act) begin
      if (tap_reg == TAP_CAP_DR) begin
        bypass_reg <= 1'b0;
        if (sel_cs) begin
          debug_scan_shift <= {1'b0, debug_control_status, 1'b0, 1'b1, 1'b0}; // [R5] [R7]
        end else if (sel_tx) begin
          debug_scan_shift <= {1'b0, tx_buf_reg, 2'b00, transmit_ready_flag}; // [R12]
        end else if (sel_rx) begin
          debug_scan_shift <= {35'h0, receive_ready_reg}; // [R15]
        end
      end else if (tap_reg == TAP_SH_DR) begin
        bypass_reg <= tdi_s;
        if (sel_dbg) begin
          debug_scan_shift <= {tdi_s, debug_scan_shift[`JDR_SCAN_W-1:1]}; // [R1] [R25]
        end
      end
    end
  end

  // update pulses toward the clk-side logic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_write_pulse_reg <= 1'b0;
      cs_update_pulse_reg <= 1'b0;
    end else begin
      rx_write_pulse_reg <= tap_act && tap_reg == TAP_UPD_DR && sel_rx;
      cs_update_pulse_reg <= tap_act && tap_reg == TAP_UPD_DR && sel_cs;
    end
  end

  // holding register; a transmit poll update leaves it alone [R13]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      debug_scan_holding <= 35'h0;
    end else if (jtag_rst) begin
      debug_scan_holding[`JDR_HOLD_VALID] <= 1'b0; // [R23]
      debug_scan_holding[1:0] <= 2'b00; // [R23]
    end else if (tap_act && tap_reg == TAP_UPD_DR && sel_cs) begin
      debug_scan_holding[33:0] <= debug_scan_shift[34:1]; // [R6]
    end else if (tap_act && tap_reg == TAP_UPD_DR && sel_rx) begin
      debug_scan_holding <= debug_scan_shift[35:1]; // [R16]
    end else if (rx_write_pulse_reg) begin
      debug_scan_holding[`JDR_HOLD_VALID] <= 1'b0; // [R18]
    end
  end

  wire rx_valid = debug_scan_holding[`JDR_HOLD_VALID];
  wire rx_flush = debug_scan_holding[`JDR_HOLD_FLUSH];
  wire rx_new = rx_write_pulse_reg & rx_valid; // [R17]

  wire apb_fin = psel & penable & pready_reg;
  wire apb_wr = apb_fin & pwrite;
  wire apb_rd = apb_fin & ~pwrite;
  wire tx_wr = apb_wr && paddr == `JDR_OFF_TX;
  wire rx_rd = apb_rd && paddr == `JDR_OFF_RX;
  wire ovf_clr = apb_wr && paddr == `JDR_OFF_HS && pwdata[`JDR_HS_OVF];
  wire tr_clr = tap_act && tap_reg == TAP_SH_DR && sel_tx && tx_cap_reg;

  // receive write logic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_buf_reg <= 32'h0;
      receive_ready_reg <= 1'b0;
      overflow_reg <= 1'b0;
      download_reg <= 1'b0;
    end else begin
      if (rx_new) begin
        rx_buf_reg <= debug_scan_holding[33:2]; // [R17]
      end
      if (rx_new) begin
        receive_ready_reg <= 1'b1; // [R19]
      end else if ((rx_write_pulse_reg && rx_flush) || rx_rd) begin
        receive_ready_reg <= 1'b0; // [R22]
      end
      if (rx_new && receive_ready_reg && !rx_flush) begin
        overflow_reg <= 1'b1; // [R20]
      end else if (ovf_clr) begin
        overflow_reg <= 1'b0;
      end
      if (rx_write_pulse_reg) begin
        download_reg <= debug_scan_holding[`JDR_HOLD_DOWNLOAD]; // [R21]
      end
    end
  end

  // transmit buffer and its ready flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_buf_reg <= 32'h0;
      transmit_ready_flag <= 1'b0;
      tx_cap_reg <= 1'b0;
    end else begin
      if (tx_wr) begin
        tx_buf_reg <= pwdata;
      end
      if (tx_wr) begin
        transmit_ready_flag <= 1'b1; // [R24]
      end else if (tr_clr) begin
        transmit_ready_flag <= 1'b0; // [R14]
      end
      if (tap_act && tap_reg == TAP_CAP_DR && sel_tx) begin
        tx_cap_reg <= transmit_ready_flag;
      end else if (tr_clr || jtag_rst) begin
        tx_cap_reg <= 1'b0;
      end
    end
  end

  // control/status register, hold-in-reset and break
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      debug_control_status <= 32'h0;
      hold_in_reset_bit <= 1'b0;
      external_break_request <= 1'b0;
    end else begin
      if (cs_update_pulse_reg) begin
        debug_control_status <= (debug_control_status & ~`JDR_DEBUG_CONTROL_STATUS_JTAG_MASK) |
                                (debug_scan_holding[33:2] & `JDR_DEBUG_CONTROL_STATUS_JTAG_MASK); // [R6] [R2]
      end else if (apb_wr && paddr == `JDR_OFF_DEBUG_CONTROL_STATUS) begin
        debug_control_status <= pwdata;
      end
      if (jtag_rst) begin
        hold_in_reset_bit <= 1'b0;
      end else if (cs_update_pulse_reg) begin
        hold_in_reset_bit <= debug_scan_holding[`JDR_HOLD_RESET]; // [R9]
      end
      if (cs_update_pulse_reg && debug_scan_holding[`JDR_HOLD_BREAK]) begin
        external_break_request <= 1'b1; // [R10]
      end else if (core_status.debug_exception) begin
        external_break_request <= 1'b0; // [R11]
      end
    end
  end

  // core-facing outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_active_reg <= 1'b0;
      core_hold_reg <= 1'b0;
      core_break_reg <= 1'b0;
    end else begin
      if (!hold_in_reset_bit) begin
        hold_active_reg <= 1'b0; // [R8]
      end else if (pin_rst) begin
        hold_active_reg <= 1'b1; // [R8]
      end
      core_hold_reg <= pin_rst | hold_active_reg; // [R8]
      core_break_reg <= external_break_request &
                        ~(core_status.monitor_mode & core_status.abort_mode) &
                        ~(core_status.halt_mode & core_status.special_debug_state); // [R11]
    end
  end

  // test data out changes on the falling tck edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo_reg <= 1'b0;
      tdo_en_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_en_reg <= (tap_reg == TAP_SH_DR) || (tap_reg == TAP_SH_IR);
      if (tap_reg == TAP_SH_IR) begin
        tdo_reg <= ir_shift_reg[0];
      end else if (tap_reg == TAP_SH_DR) begin
        tdo_reg <= sel_dbg ? debug_scan_shift[0] : bypass_reg; // [R25]
      end
    end
  end

  // apb read decode
  always_comb begin
    rdata_next = 32'h0;
    hit_next = 1'b1;
    unique case (paddr)
      `JDR_OFF_DEBUG_CONTROL_STATUS: rdata_next = debug_control_status;
      `JDR_OFF_TX: rdata_next = tx_buf_reg;
      `JDR_OFF_RX: rdata_next = rx_buf_reg;
      `JDR_OFF_HS: rdata_next = {receive_ready_reg, overflow_reg, download_reg, transmit_ready_flag, 28'h0};
      `JDR_OFF_STATUS: rdata_next = {29'h0, hold_active_reg, external_break_request, hold_in_reset_bit};
      default: hit_next = 1'b0;
    endcase
  end

  // apb slave answers after one wait state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      if (psel && penable && !pready_reg) begin
        prdata_reg <= pwrite ? 32'h0 : rdata_next;
        pslverr_reg <= ~hit_next;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign tdo = tdo_reg;
  assign tdo_en = tdo_en_reg;
  assign core_hold_reset = core_hold_reg;
  assign core_break_request = core_break_reg;

  a_scan_lsb_first: assert property (@(posedge clk) disable iff (!rst_b) // [R1] [R25]
    tap_act && tap_reg == TAP_SH_DR && sel_dbg |=> debug_scan_shift == {$past(tdi_s), $past(debug_scan_shift[35:1])})
    else $error("scan register did not shift lsb first");
  a_cs_capture_value: assert property (@(posedge clk) disable iff (!rst_b) // [R5] [R7]
    tap_act && tap_reg == TAP_CAP_DR && sel_cs |=> debug_scan_shift[34:0] == {$past(debug_control_status), 3'b010})
    else $error("control status capture wrong");
  a_tx_capture_value: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
    tap_act && tap_reg == TAP_CAP_DR && sel_tx |=>
      debug_scan_shift[34:3] == $past(tx_buf_reg) && debug_scan_shift[0] == $past(transmit_ready_flag))
    else $error("transmit capture wrong");
  a_rx_capture_ready: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
    tap_act && tap_reg == TAP_CAP_DR && sel_rx |=> debug_scan_shift[0] == $past(receive_ready_reg))
    else $error("receive capture lost ready bit");
  a_rx_hold_load: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
    tap_act && tap_reg == TAP_UPD_DR && sel_rx |=> debug_scan_holding == $past(debug_scan_shift[35:1]))
    else $error("receive update did not load holding");
  a_tx_update_inert: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
    tap_act && tap_reg == TAP_UPD_DR && sel_tx && !rx_write_pulse_reg |=> $stable(debug_scan_holding))
    else $error("transmit update changed holding");
  a_valid_self_clear: assert property (@(posedge clk) disable iff (!rst_b) // [R18]
    rx_write_pulse_reg && !jtag_rst |=> !debug_scan_holding[`JDR_HOLD_VALID])
    else $error("valid holding bit not cleared");
  a_rx_write_ready: assert property (@(posedge clk) disable iff (!rst_b) // [R19] [R17]
    rx_new |=> receive_ready_reg && rx_buf_reg == $past(debug_scan_holding[33:2]))
    else $error("receive write did not land");
  a_rx_poll_inert: assert property (@(posedge clk) disable iff (!rst_b) // [R17]
    rx_write_pulse_reg && !rx_valid |=> $stable(rx_buf_reg))
    else $error("poll update changed receive buffer");
  a_overflow_set: assert property (@(posedge clk) disable iff (!rst_b) // [R20]
    rx_new && receive_ready_reg && !rx_flush |=> overflow_reg)
    else $error("overflow not flagged");
  a_download_copy: assert property (@(posedge clk) disable iff (!rst_b) // [R21]
    rx_write_pulse_reg |=> download_reg == $past(debug_scan_holding[`JDR_HOLD_DOWNLOAD]))
    else $error("download flag not copied");
  a_flush_clears: assert property (@(posedge clk) disable iff (!rst_b) // [R22]
    rx_write_pulse_reg && rx_flush && !rx_valid |=> !receive_ready_reg)
    else $error("flush left receive ready set");
  a_trst_clears: assert property (@(posedge clk) disable iff (!rst_b) // [R23]
    jtag_rst |=> !debug_scan_holding[34] && !debug_scan_holding[1] && !debug_scan_holding[0])
    else $error("test reset left holding bits set");
  a_hold_release: assert property (@(posedge clk) disable iff (!rst_b) // [R8] [R9]
    cs_update_pulse_reg && !debug_scan_holding[0] && !jtag_rst ##1 !pin_rst [*2] |=> !core_hold_reset)
    else $error("core not released from hold");
  a_break_pending: assert property (@(posedge clk) disable iff (!rst_b) // [R10] [R11]
    cs_update_pulse_reg && debug_scan_holding[1] |=> external_break_request)
    else $error("break request not pended");
  a_break_deferred: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
    core_status.halt_mode && core_status.special_debug_state |=> !core_break_request)
    else $error("break not deferred");
  a_tr_read_clear: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
    tr_clr && !tx_wr |=> !transmit_ready_flag)
    else $error("shift-out read did not clear transmit ready");
  a_tr_write_set: assert property (@(posedge clk) disable iff (!rst_b) // [R24]
    tx_wr |=> transmit_ready_flag ##0 tx_buf_reg == $past(pwdata))
    else $error("handler write did not set transmit ready");

  c_rx_write: cover property (@(posedge clk) disable iff (!rst_b) rx_new);
  c_overflow: cover property (@(posedge clk) disable iff (!rst_b) rx_new && receive_ready_reg);
  c_tr_clear: cover property (@(posedge clk) disable iff (!rst_b) tr_clr);
  c_hold_in_reset: cover property (@(posedge clk) disable iff (!rst_b) hold_active_reg && !pin_rst);

endmodule : jdr_top

// >>> jdr_defines.svh
// constants for the debug scan data registers: instruction codes, scan layout,
// handshake bit positions and register offsets.
// assumes the include guard keeps repeated inclusion by package, design and bench harmless.
`ifndef JDR_DEFINES_SVH
`define JDR_DEFINES_SVH

`define JDR_IR_W 5
`define JDR_SCAN_W 36
`define JDR_HOLD_W 35
`define JDR_IR_CTRL_STATUS 5'h09
`define JDR_IR_TRANSMIT_POLL 5'h10
`define JDR_IR_RECEIVE_WRITE 5'h02
`define JDR_IR_RESET_VALUE 5'h1f
`define JDR_IR_CAPTURE_VALUE 5'h01

// holding register field positions
`define JDR_HOLD_VALID 34
`define JDR_HOLD_FLUSH 1
`define JDR_HOLD_DOWNLOAD 0
`define JDR_HOLD_BREAK 1
`define JDR_HOLD_RESET 0

// handshake control bit positions
`define JDR_HS_RR 31
`define JDR_HS_OVF 30
`define JDR_HS_DL 29
`define JDR_HS_TR 28

// control/status bits that the scan path may change
`define JDR_DEBUG_CONTROL_STATUS_JTAG_MASK 32'hc000_00ff

// register map, byte addresses
`define JDR_ADDR_W 12
`define JDR_OFF_DEBUG_CONTROL_STATUS 12'h000
`define JDR_OFF_TX 12'h004
`define JDR_OFF_RX 12'h008
`define JDR_OFF_HS 12'h00c
`define JDR_OFF_STATUS 12'h010

`endif

// >>> jdr_pkg.sv
// types shared by the debug scan data register block.
// assumes jdr_defines.svh is on the include path.
`include "jdr_defines.svh"

package jdr_pkg;

  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001,
    TAP_RTI = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PAU_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PAU_IR = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } jdr_tap_state_t;

  // core state that steers the external break
  typedef struct packed {
    logic debug_exception;
    logic monitor_mode;
    logic abort_mode;
    logic halt_mode;
    logic special_debug_state;
  } jdr_core_status_t;

endpackage : jdr_pkg

// >>> jdr_jtag_host.sv
// debugger model: drives tck/tms/tdi/trst_b, samples tdo.
// assumes clk is the bench clock; tck runs only inside scans, 320 ns period.
module jdr_jtag_host (
  input wire logic clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_b = 1'b0;
  end
  // tdo is taken at the end of the high phase, where it is settled
  task automatic tick(input logic m, input logic d, output logic o);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    o = tdo;
  endtask : tick
  task automatic walk(input logic [7:0] seq, input int n);
    logic o;
    for (int i = 0; i < n; i++) tick(seq[i], 1'b0, o);
    tck <= 1'b0;
    tdi <= ~tdi;
    repeat (4) @(posedge clk);
  endtask : walk
  task automatic shift(input logic [35:0] din, input int n, output logic [35:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
  endtask : shift
  task automatic trst_pulse();
    trst_b <= 1'b0;
    repeat (8) @(posedge clk);
    trst_b <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : trst_pulse
  task automatic scan_ir(input logic [4:0] code);
    logic [35:0] o;
    walk(8'h03, 4);
    shift({31'h0, code}, 5, o);
    walk(8'h01, 2);
  endtask : scan_ir
  // every scan_dr passes through shift, so a transmit capture it makes is always read out
  task automatic scan_dr(input logic [35:0] din, output logic [35:0] dout);
    walk(8'h01, 3);
    shift(din, 36, dout);
    walk(8'h01, 2);
  endtask : scan_dr
endmodule : jdr_jtag_host

// >>> testbench.sv
// self-checking bench for jdr_top: apb handler side, debugger model on jtag.
// assumes jdr_defines.svh on the include path.
`include "jdr_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import jdr_pkg::*;
  logic clk, rst_b, tck, tms, tdi, trst_b, sys_reset_pin, psel, penable, pwrite;
  logic pready, pslverr, tdo, tdo_en, core_hold_reset, core_break_request, e;
  jdr_core_status_t core_status;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, d, d2, v, w;
  integer seed;
  logic [35:0] so;
  int err_total, tests_run;
  jdr_top jdr_top_inst (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b),
    .sys_reset_pin(sys_reset_pin), .core_status(core_status), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .tdo(tdo), .tdo_en(tdo_en), .core_hold_reset(core_hold_reset),
    .core_break_request(core_break_request));
  jdr_jtag_host jdr_jtag_host_inst (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw);
    return (old & ~`JDR_DEBUG_CONTROL_STATUS_JTAG_MASK) | (nw & `JDR_DEBUG_CONTROL_STATUS_JTAG_MASK);
  endfunction : merge
  function automatic logic [35:0] rx_word(input logic vb, input logic [31:0] dt, input logic fl, input logic dl);
    return {vb, dt, fl, dl, 1'h0};
  endfunction : rx_word
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic dr(input logic [35:0] i);
    jdr_jtag_host_inst.scan_dr(i, so);
  endtask : dr
  task automatic wait_chk(input logic got_exp);
    repeat (6) @(posedge clk);
    chk(core_break_request, got_exp);
  endtask : wait_chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  initial begin
    seed = 32'hef57142e;
    {rst_b, sys_reset_pin, psel, penable, pwrite, paddr, pwdata} = '0;
    core_status = '0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    jdr_jtag_host_inst.trst_pulse();
    jdr_jtag_host_inst.walk(8'h3f, 7);
    apb(1'b0, 12'h014, 32'h0);
    chk({e, r}, 36'h100000000);
    apb(1'b0, 12'h006, 32'h0);
    chk({e, r}, 36'h100000000);
    d = $random(seed);
    apb(1'b1, `JDR_OFF_TX, d);
    apb(1'b0, `JDR_OFF_HS, 32'h0);
    chk(r[28], 1'h1);
    jdr_jtag_host_inst.scan_ir(`JDR_IR_TRANSMIT_POLL);
    dr({$random(seed), 4'hf});
    chk(so[34:3], d);
    chk(so[0], 1'h1);
    apb(1'b0, `JDR_OFF_HS, 32'h0);
    chk(r[28], 1'h0);
    dr({$random(seed), 4'h5});
    chk(so[0], 1'h0);
    apb(1'b0, `JDR_OFF_TX, 32'h0);
    chk(r, d);
    jdr_jtag_host_inst.scan_ir(`JDR_IR_RECEIVE_WRITE);
    d = $random(seed);
    d2 = $random(seed);
    dr(rx_word(1'h1, d, 1'h0, 1'h1));
    apb(1'b0, `JDR_OFF_HS, 32'h0);
    chk(r[31:29], 3'h5);
    dr(rx_word(1'h1, d2, 1'h0, 1'h1));
    chk(so[0], 1'h1);
    apb(1'b0, `JDR_OFF_HS, 32'h0);
    chk(r[31:29], 3'h7);
    dr(rx_word(1'h0, $random(seed), 1'h1, 1'h0));
    chk(so[0], 1'h1);
    apb(1'b0, `JDR_OFF_HS, 32'h0);
    chk(r[31:29], 3'h2);
    apb(1'b0, `JDR_OFF_RX, 32'h0);
    chk(r, d2);
    apb(1'b1, `JDR_OFF_HS, 32'h4000_0000);
    apb(1'b0, `JDR_OFF_HS, 32'h0);
    chk(r[31:29], 3'h0);
    v = $random(seed);
    apb(1'b1, `JDR_OFF_DEBUG_CONTROL_STATUS, v);
    jdr_jtag_host_inst.scan_ir(`JDR_IR_CTRL_STATUS);
    jdr_jtag_host_inst.walk(8'h35, 7);
    apb(1'b0, `JDR_OFF_STATUS, 32'h0);
    chk(r[1:0], 2'h1);
    apb(1'b0, `JDR_OFF_DEBUG_CONTROL_STATUS, 32'h0);
    chk(r, v);
    sys_reset_pin <= 1'b1;
    repeat (10) @(posedge clk);
    sys_reset_pin <= 1'b0;
    repeat (10) @(posedge clk);
    chk(core_hold_reset, 1'h1);
    w = $random(seed);
    dr({1'h0, w, 3'h6});
    chk(so[34:3], v);
    chk(so[1], 1'h1);
    chk(core_hold_reset, 1'h1);
    apb(1'b0, `JDR_OFF_DEBUG_CONTROL_STATUS, 32'h0);
    chk(r, merge(v, w));
    chk(core_break_request, 1'h1);
    core_status <= '{halt_mode: 1'b1, special_debug_state: 1'b1, default: 1'b0};
    wait_chk(1'h0);
    core_status <= '{monitor_mode: 1'b1, abort_mode: 1'b1, default: 1'b0};
    wait_chk(1'h0);
    core_status <= '0;
    wait_chk(1'h1);
    core_status <= '{debug_exception: 1'b1, default: 1'b0};
    @(posedge clk);
    core_status <= '0;
    wait_chk(1'h0);
    dr({1'h0, w, 3'h0});
    repeat (6) @(posedge clk);
    chk(core_hold_reset, 1'h0);
    jdr_jtag_host_inst.walk(8'h35, 7);
    jdr_jtag_host_inst.trst_pulse();
    apb(1'b0, `JDR_OFF_STATUS, 32'h0);
    chk(r[0], 1'h0);
    jdr_jtag_host_inst.walk(8'h02, 4);
    chk({tdo_en, tdo}, 2'h2);
    jdr_jtag_host_inst.walk(8'h03, 3);
    chk(tdo_en, 1'h0);
    print_verdict();
  end
endmodule : testbench
